// ===== design/rtimer_map.svh
// Register offsets, bit positions, reset values and counts of the timer chain
`ifndef RTIMER_MAP_SVH
`define RTIMER_MAP_SVH
`define ADDR_W 4
`define OFF_CTRL_STAT 4'h0
`define OFF_COUNT 4'h1
`define OFF_IRQ_STAT 4'h2
`define OFF_IRQ_MASK 4'h3
`define BIT_OVF_FLAG 7
`define BIT_PER_FLAG 6
`define BIT_OVF_IE 5
`define BIT_PER_IE 4
`define BIT_OVF_ACK 3
`define BIT_PER_ACK 2
`define BIT_RATE_HI 1
`define BIT_RATE_LO 0
`define RATE_RESET 2'h3
`define PRESCALE_DIV 4
`define RTI_BASE_LOG2 13
`define POR_CYCLES 4064
`define CHAIN_W 17
`define SWITCH_HOLD_MAX 4
`endif

// ===== design/rtimer_pkg.sv
// Types shared by the timer chain design
package rtimer_pkg;
  typedef enum logic [1:0] {
    ST_POR_COUNT,
    ST_POR_CLEAR,
    ST_RUN
  } chain_state_t;
  typedef logic [7:0] byte_t;
endpackage : rtimer_pkg

// ===== design/ripple_timer.sv
// Free-running timer chain with overflow and periodic interrupt flags
`timescale 1ns/10ps
`include "rtimer_map.svh"

// Functional notes
// - Overflow flag sets on counter wrap to zero
// - Overflow flag plus enable requests interrupt
// - Overflow ack write-one clears; reads zero
// - Periodic path: divide 8192, four stages, selector
// - Periodic flag sets when selected stage activates
// - Periodic flag plus enable requests interrupt
// - Periodic ack write-one clears; reads zero
// - Rate codes give 2^14 to 2^17 cycles
// - Reset sets both rate select bits
// - Reset clears flags and interrupt enables
// - Count register read-only, returns live counter
// - Counter advances every four operating cycles
// - Power-on: count 4064 cycles, clear again
// - After release chain counts up from zero
// - External reset clears the whole chain
// - Clock switch holds timer still
// - Overflow recurs every 1024 operating cycles
module ripple_timer
  import rtimer_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Chip-level controls
  input wire logic ext_reset,
  input wire logic clk_switching,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Outputs
  output logic cpu_irq,
  output logic irq_out,
  output logic por_active
);

  // Whole divider chain: bits 1:0 prescale, 9:2 visible counter
  logic [`CHAIN_W-1:0] chain_reg;
  // Power-on sequencer state and its cycle counter
  chain_state_t state_reg;
  logic [11:0] por_cnt_reg;
  // Status and control bits
  logic overflow_flag_reg;
  logic periodic_flag_reg;
  logic overflow_irq_enable_reg;
  logic periodic_irq_enable_reg;
  logic [1:0] periodic_rate_select_reg;
  // Sticky event status and mask for the aggregate interrupt
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  // Previous selected tap level for edge detection
  logic tap_prev_reg;

  // Derived strobes
  logic advance;
  logic chain_clear;
  logic wrap_evt;
  logic tap_now;
  logic tap_evt;
  logic wr_cs;
  logic wr_stat;

  // The chain moves in power-on count and run states with the bus clock steady
  assign advance = (state_reg != ST_POR_CLEAR) && !clk_switching;
  assign chain_clear = (state_reg == ST_POR_CLEAR) || ext_reset;
  // Counter wraps when chain bits 9:0 are all ones and it advances
  assign wrap_evt = advance && !chain_clear && (state_reg == ST_RUN)
                    && (&chain_reg[9:0]);
  // Taps at bits 13..16 give periods 2^14 .. 2^17
  assign tap_now = chain_reg[`RTI_BASE_LOG2 + periodic_rate_select_reg];
  // A rate change may land on a different tap level: that is the
  // documented hazard software must avoid, not filtered here
  assign tap_evt = tap_now && !tap_prev_reg && (state_reg == ST_RUN);
  assign wr_cs = reg_wr && (reg_addr == `OFF_CTRL_STAT);
  assign wr_stat = reg_wr && (reg_addr == `OFF_IRQ_STAT);

  // Power-on sequencer: count, then clear once, then run
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_POR_COUNT;
      por_cnt_reg <= 12'h000;
    end else begin
      case (state_reg)
        ST_POR_COUNT: begin
          // Counted on the raw clock; power-on has no switching
          if (por_cnt_reg == 12'(`POR_CYCLES - 1)) begin
            state_reg <= ST_POR_CLEAR;
          end else begin
            por_cnt_reg <= por_cnt_reg + 12'h001;
          end
        end
        ST_POR_CLEAR: begin
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_POR_COUNT;
        end
      endcase
    end
  end

  // Divider chain: free-running, no software enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chain_reg <= '0;
    end else if (chain_clear) begin
      chain_reg <= '0;
    end else if (advance) begin
      chain_reg <= chain_reg + `CHAIN_W'(1);
    end
  end

  // Edge detector memory for the selected tap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tap_prev_reg <= 1'b0;
    end else begin
      tap_prev_reg <= tap_now;
    end
  end

  // Overflow flag: set wins over acknowledge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag_reg <= 1'b0;
    end else if (wrap_evt) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_cs && reg_wdata[`BIT_OVF_ACK]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  // Periodic flag: set wins over acknowledge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      periodic_flag_reg <= 1'b0;
    end else if (tap_evt) begin
      periodic_flag_reg <= 1'b1;
    end else if (wr_cs && reg_wdata[`BIT_PER_ACK]) begin
      periodic_flag_reg <= 1'b0;
    end
  end

  // Control bits written through the control/status register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq_enable_reg <= 1'b0;
      periodic_irq_enable_reg <= 1'b0;
      periodic_rate_select_reg <= `RATE_RESET;
    end else if (wr_cs) begin
      overflow_irq_enable_reg <= reg_wdata[`BIT_OVF_IE];
      periodic_irq_enable_reg <= reg_wdata[`BIT_PER_IE];
      periodic_rate_select_reg <= reg_wdata[`BIT_RATE_HI:`BIT_RATE_LO];
    end
  end

  // Sticky event status, write one to clear; a new event wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? reg_wdata[1:0] : 2'h0))
                      | {tap_evt, wrap_evt};
    end
  end

  // Mask for the aggregate interrupt
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_reg <= 2'h0;
    end else if (reg_wr && (reg_addr == `OFF_IRQ_MASK)) begin
      irq_mask_reg <= reg_wdata[1:0];
    end
  end

  // Interrupt outputs registered from current register values
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpu_irq <= 1'b0;
      irq_out <= 1'b0;
      por_active <= 1'b1;
    end else begin
      cpu_irq <= (overflow_flag_reg && overflow_irq_enable_reg)
                 || (periodic_flag_reg && periodic_irq_enable_reg);
      irq_out <= |(irq_stat_reg & irq_mask_reg);
      por_active <= (state_reg != ST_RUN);
    end
  end

  // Read data one cycle after the strobe; acks read as zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFF_CTRL_STAT: reg_rdata <= {overflow_flag_reg, periodic_flag_reg,
          overflow_irq_enable_reg, periodic_irq_enable_reg, 2'h0,
          periodic_rate_select_reg};
        `OFF_COUNT: reg_rdata <= chain_reg[9:2];
        `OFF_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_reg};
        `OFF_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Overflow flag rises one cycle after a counter wrap
  ovf_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wrap_evt |=> overflow_flag_reg)
    else $error("overflow flag not set after wrap");
  // Interrupt follows overflow flag and enable
  ovf_irq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overflow_flag_reg && overflow_irq_enable_reg) |=> cpu_irq)
    else $error("overflow interrupt missing");
  // Ack clears overflow flag unless a wrap coincides
  ovf_ack_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wr_cs && reg_wdata[`BIT_OVF_ACK] && !wrap_evt) |=> !overflow_flag_reg)
    else $error("overflow ack failed");
  // Periodic flag rises after a tap edge
  per_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tap_evt |=> periodic_flag_reg)
    else $error("periodic flag not set");
  // Interrupt follows periodic flag and enable
  per_irq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (periodic_flag_reg && periodic_irq_enable_reg) |=> cpu_irq)
    else $error("periodic interrupt missing");
  // Ack clears periodic flag unless a tap edge coincides
  per_ack_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wr_cs && reg_wdata[`BIT_PER_ACK] && !tap_evt) |=> !periodic_flag_reg)
    else $error("periodic ack failed");
  // Count register returns the counter of the previous cycle
  count_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == `OFF_COUNT) |=> reg_rdata == $past(chain_reg[9:2]))
    else $error("count read mismatch");
  // Chain clears after external reset
  ext_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ext_reset |=> chain_reg == '0)
    else $error("chain not cleared");
  // Chain holds during clock switching outside clears
  switch_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clk_switching && !chain_clear) |=> $stable(chain_reg))
    else $error("chain moved during switch");
  // Visible counter steps by one on every fourth advance
  sequence four_adv_s;
    (advance && !chain_clear && chain_reg[1:0] == 2'h3);
  endsequence
  count_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    four_adv_s |=> chain_reg[9:2] == $past(chain_reg[9:2]) + 8'h01)
    else $error("counter step wrong");

  // Power-on sequencer checks. The counter reaches its last value once and
  // must hand over to the single clear cycle, which in turn must lead into
  // run state with the chain at zero and the power-on output dropped.
  // Multi-step behaviour is built from named sequences so each step reads
  // on its own.
  sequence clear_step_s;
    state_reg == ST_POR_CLEAR;
  endsequence
  sequence run_entry_s;
    (state_reg == ST_RUN && chain_reg == '0) ##1 !por_active;
  endsequence
  // Last power-on count moves to the clear cycle
  por_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (state_reg == ST_POR_COUNT && por_cnt_reg == 12'(`POR_CYCLES - 1))
    |=> state_reg == ST_POR_CLEAR)
    else $error("power-on count did not end");
  // Clear cycle leads to run from zero
  por_exit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clear_step_s |=> run_entry_s)
    else $error("power-on exit sequence wrong");
  // Run state is never left without a reset
  run_stay_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_reg == ST_RUN |=> state_reg == ST_RUN)
    else $error("run state left");

  // Flag checks. A flag may only rise because of its own event, and once
  // up it stays up until software acknowledges it; this is what lets a
  // polling loop miss nothing even with its interrupt disabled.
  ovf_rise_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(overflow_flag_reg) |-> $past(wrap_evt))
    else $error("overflow flag rose without wrap");
  per_rise_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(periodic_flag_reg) |-> $past(tap_evt))
    else $error("periodic flag rose without tap edge");
  // Overflow flag is sticky without an acknowledge
  ovf_sticky_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overflow_flag_reg && !(wr_cs && reg_wdata[`BIT_OVF_ACK]))
    |=> overflow_flag_reg)
    else $error("overflow flag dropped");
  // Periodic flag is sticky without an acknowledge
  per_sticky_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (periodic_flag_reg && !(wr_cs && reg_wdata[`BIT_PER_ACK]))
    |=> periodic_flag_reg)
    else $error("periodic flag dropped");

  // Interrupt output checks. The request must also fall once neither
  // flag is enabled, otherwise a handler would be re-entered forever.
  irq_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!(overflow_flag_reg && overflow_irq_enable_reg)
     && !(periodic_flag_reg && periodic_irq_enable_reg)) |=> !cpu_irq)
    else $error("interrupt request without cause");
  // Aggregate level follows unmasked sticky status
  agg_irq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|(irq_stat_reg & irq_mask_reg)) |=> irq_out)
    else $error("aggregate interrupt missing");

  // Register port checks. Acknowledge positions read as zero so that a
  // read-modify-write of the control register never clears a flag.
  ack_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == `OFF_CTRL_STAT) |=> reg_rdata[3:2] == 2'h0)
    else $error("acknowledge bits read nonzero");
  // Rate field takes the written code
  rate_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_cs |=> periodic_rate_select_reg == $past(reg_wdata[1:0]))
    else $error("rate select not written");
  // Read data return to zero outside the answer cycle
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");

endmodule : ripple_timer

// ===== test/ripple_timer_with_rti_bench.sv
// Self-checking bench for the ripple timer chain
`timescale 1ns/10ps
`include "rtimer_map.svh"
module ripple_timer_with_rti_bench;
  // Clock, reset and chip-level controls
  logic clk_sys = 0;
  logic arst_n = 0;
  logic ext_reset = 0;
  logic clk_switching = 0;
  // Register port
  logic [`ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_rdata;
  // Outputs
  logic cpu_irq;
  logic irq_out;
  logic por_active;
  // Bookkeeping
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t1;
  int n;
  logic [7:0] rd;
  logic [7:0] c0;
  logic [16:0] lfsr = 17'h11c4c;

  always #5 clk_sys = ~clk_sys;
  // Free cycle count used to time flag intervals
  always @(posedge clk_sys) cyc <= cyc + 1;

  ripple_timer uut (.clk_sys, .arst_n, .ext_reset, .clk_switching,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_irq,
    .irq_out, .por_active);

  // Seventeen-bit shift register for random control writes
  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr_next

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Step just past an edge so outputs have settled
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick();
    reg_wr <= 1'b0;
    // Idle cycle so a following strobe never lands in this time step
    tick();
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick();
    reg_rd <= 1'b0;
    rd = reg_rdata;
    tick();
  endtask : rdr

  // Bounded wait: 0 cpu_irq, 1 irq_out, 2 por_active
  task automatic wait_sig(input int sel, input logic want, input int bound);
    n = 0;
    while ((sel == 0 ? cpu_irq : sel == 1 ? irq_out : por_active) !== want)
    begin
      tick();
      n++;
      if (n > bound) begin
        num_errors++;
        $display("Timeout waiting on output %0d", sel);
        final_report();
      end
    end
  endtask : wait_sig

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    arst_n <= 1'b1;
    t1 = cyc;
    tick();
    chk(por_active, 1);
    rdr(`OFF_CTRL_STAT);
    chk(rd, {6'h00, `RATE_RESET});
    wait_sig(2, 1'b0, 5000);
    chk((cyc - t1) inside {[4064:4072]}, 1);
    rdr(`OFF_COUNT);
    chk(rd <= 8'h02, 1);
    $display("Test power-on done");
    // Count register is live and ignores writes; 148 cycles apart
    rdr(`OFF_COUNT);
    c0 = rd;
    wr(`OFF_COUNT, 8'h00);
    repeat (144) tick();
    rdr(`OFF_COUNT);
    chk(8'(rd - c0), 8'd37);
    rdr(4'hf);
    chk(rd, 8'h00);
    // Switching clock source freezes the chain
    clk_switching <= 1'b1;
    repeat (3) tick();
    rdr(`OFF_COUNT);
    c0 = rd;
    repeat (20) tick();
    rdr(`OFF_COUNT);
    chk(rd, c0);
    clk_switching <= 1'b0;
    ext_reset <= 1'b1;
    repeat (3) tick();
    rdr(`OFF_COUNT);
    chk(rd, 8'h00);
    ext_reset <= 1'b0;
    $display("Test counter done");
    // Overflow interval measured between two interrupt rises
    wr(`OFF_CTRL_STAT, 8'h2b);
    wait_sig(0, 1'b1, 1100);
    t1 = cyc;
    rdr(`OFF_CTRL_STAT);
    chk({rd[7], rd[3]}, 2'b10);
    wr(`OFF_CTRL_STAT, 8'h2b);
    wait_sig(0, 1'b0, 8);
    wait_sig(0, 1'b1, 1100);
    chk(cyc - t1, 1024);
    // Sticky status with mask drives the level interrupt
    wr(`OFF_IRQ_MASK, 8'h01);
    wr(`OFF_IRQ_STAT, 8'h03);
    wait_sig(1, 1'b0, 8);
    wait_sig(1, 1'b1, 1100);
    rdr(`OFF_IRQ_STAT);
    chk(rd[0], 1);
    wr(`OFF_IRQ_STAT, 8'h01);
    repeat (2) tick();
    chk(irq_out, 0);
    $display("Test overflow done");
    // Shortest periodic rate; the first event after a change is not timed
    wr(`OFF_CTRL_STAT, 8'h1c);
    wait_sig(0, 1'b0, 8);
    wait_sig(0, 1'b1, 17000);
    t1 = cyc;
    rdr(`OFF_CTRL_STAT);
    chk({rd[6], rd[2], rd[1:0]}, 4'b1000);
    wr(`OFF_CTRL_STAT, 8'h14);
    wait_sig(0, 1'b0, 8);
    wait_sig(0, 1'b1, 17000);
    chk(cyc - t1, 16384);
    wr(`OFF_CTRL_STAT, 8'h00);
    repeat (2) tick();
    chk(cpu_irq, 0);
    $display("Test periodic done");
    // Random control writes: enables and rate read back, acks read zero
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      wr(`OFF_CTRL_STAT, lfsr[7:0]);
      rdr(`OFF_CTRL_STAT);
      chk(rd & 8'h3f, lfsr[7:0] & 8'h33);
    end
    // Second reset in mid-run restores the reset layout
    arst_n <= 1'b0;
    tick();
    arst_n <= 1'b1;
    tick();
    rdr(`OFF_CTRL_STAT);
    chk(rd, 8'h03);
    $display("Test random and reset done");
    final_report();
  end
endmodule : ripple_timer_with_rti_bench
